// ---- pin_load.sv ----
// external load model that resolves the channel pin lines
`timescale 1ns/1ps
module pin_load
(
  // driven pins
  input wire channel0_pin,
  input wire channel0_pin_oe,
  input wire channel1_pin,
  input wire channel1_pin_oe,
  // resolved lines
  output wire line0,
  output wire line1
);
  // a released pin falls to the pull-down level
  assign line0 = channel0_pin_oe ? channel0_pin : 1'b0;
  assign line1 = channel1_pin_oe ? channel1_pin : 1'b0;
endmodule // pin_load

// ---- pwm_timer.v ----
// two-channel 16-bit timer with buffered pwm output compare and avalon-mm register slave
//
// Summary of operation
// [R1] link bit pairs channels, channel 0 first
// [R2] channel 1 write takes over at overflow
// [R3] each overflow selects last written set
// [R4] linked: channel 0 control, channel 1 ignored
// [R5] linked: channel 1 pin released to gpio
// [R6] link bit beats lower mode bit
// [R7] toggle pin at modulo overflow
// [R8] compare match applies set or clear
// [R9] modulo 255 divide one: 256 clocks
// [R10] compare 128 of 256 gives half
// [R11] software times unbuffered width updates
// [R12] software avoids toggle on compare
// [R13] software leaves active set unwritten
// [R14] software halts, programs, then releases
// [R15] mode 01 unbuffered, 10 buffered
// [R16] edge level 10 clears, 11 sets
// [R17] no overflow toggle gives 0% duty
// [R18] max duty without toggle gives 100%
// [R19] overflow flag, gated overflow interrupt
// [R20] channel flag on compare, gated interrupt
// [R21] wait mode runs, bus locked out
// [R22] stop mode freezes all state
// [R23] prescale 1 to 64, code 7 external
// [R24] counter reset clears counter, prescaler
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "pwm_timer_regs.vh"
module pwm_timer
#(
  parameter CNT_W = 16
)
(
  // clock and reset
  input wire clock,
  input wire arst_n,
  // power modes
  input wire wait_mode,
  input wire stop_mode,
  // external timer clock pin
  input wire external_timer_clock_pin,
  // avalon-mm slave
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // channel pins
  output reg channel0_pin,
  output reg channel0_pin_oe,
  output reg channel1_pin,
  output reg channel1_pin_oe,
  // interrupt requests
  output reg overflow_irq_ff,
  output reg ch0_irq_ff,
  output reg ch1_irq_ff
);

////////////////////////////////////////////////////////////////////////////////
// design notes
// bus: a request is taken at the first edge it is seen
// bus: waitrequest drops for one cycle, one wait state
// bus: write lands at that first edge, read data registered there
// bus: nothing is answered in wait or stop mode
// bus: only the low byte of each word carries data
// pairs: high byte write is held until the low byte
// pairs: modulo high write masks the overflow flag
// pairs: counter high read freezes the low byte
// counter: steps only on a prescaler tick
// counter: wraps to zero on the tick that meets the modulo
// counter: halt and stop both hold it and the prescaler
// counter: reset bit clears counter and prescaler only
// compare: matched against the next count value
// compare: so the pin is high for exactly the compare count
// compare: a compare of zero wins over the overflow toggle
// compare: so zero width gives a clean 0% output
// pins: two flops from tick to pin, internal and output
// pins: output enable follows the channel mode bits
// pins: linked pair drives channel 0, channel 1 released
// linked: channel 1 low byte write arms a handover
// linked: channel 0 low byte write arms the way back
// linked: handover happens only at an overflow
// linked: writing the active set acts as unbuffered
// flags: set wins over a clear in the same cycle
// flags: clear needs a read with the flag set, then a zero
// flags: an event between the two steps keeps the flag
// flags: any write to the register ends the sequence
// irq: requests are flag and enable, one cycle late
// irq: channel 1 request is masked while linked
// limits: external clock must be no faster than half the bus
// limits: the external pin is taken as synchronous

////////////////////////////////////////////////////////////////////////////////
// registers
reg overflow_flag_ff, overflow_irq_enable_ff, counter_halt_ff;
reg [2:0] prescale_select_ff;
reg [CNT_W-1:0] counter_ff, counter_modulo_value_ff;
reg [7:0] modh_buf_ff;
reg mod_pend_ff;
reg [7:0] cnth_latch_ff;
reg cnt_latched_ff;
reg [7:0] sc_ff [0:1];
reg [CNT_W-1:0] cmp_ff [0:1];
reg [7:0] chh_buf_ff [0:1];
reg active_sel_ff;
reg pending_sel_ff;
reg [6:0] presc_ff;
reg ext_d_ff;
reg ack_ff;
reg ovf_read_ff;
reg [1:0] chf_read_ff;
reg [1:0] pin_ff;

wire [3:0] idx = avs_address[5:2];
wire bus_ok = ~wait_mode & ~stop_mode; // [R21]
wire wr = avs_write & bus_ok & ~ack_ff;
wire rd = avs_read & bus_ok & ~ack_ff;
wire [7:0] wd = avs_writedata[7:0];
wire link = sc_ff[0][`SC_MSB]; // [R1] [R6]
wire run = ~stop_mode & ~counter_halt_ff; // [R22]
wire crst = wr && idx == `TSC_IDX && wd[`TSC_CRST]; // [R24]
// write strobes of the registers holding flags
wire wr_tsc = wr && idx == `TSC_IDX;
wire wr_sc0 = wr && idx == `SC0_IDX;
wire wr_sc1 = wr && idx == `SC1_IDX;

////////////////////////////////////////////////////////////////////////////////
// prescaler tap mask: low bits that must all be ones for a tick
reg [6:0] presc_mask;
always @*
begin
  presc_mask = 7'h00;
  case (prescale_select_ff)
    3'h0: presc_mask = 7'h00;
    3'h1: presc_mask = 7'h01;
    3'h2: presc_mask = 7'h03;
    3'h3: presc_mask = 7'h07;
    3'h4: presc_mask = 7'h0F;
    3'h5: presc_mask = 7'h1F;
    3'h6: presc_mask = 7'h3F;
    default: presc_mask = 7'h7F;
  endcase
end

// prescaler tick: bus divided by 2^code, or rising edge of external pin
reg tick;
always @*
begin
  tick = 1'b0;
  if (prescale_select_ff == `PS_EXT) // [R23]
    tick = external_timer_clock_pin & ~ext_d_ff;
  else
    tick = (presc_ff & presc_mask) == presc_mask; // [R23]
  tick = tick & run;
end

wire at_mod = counter_ff == counter_modulo_value_ff;
wire ovf = tick & at_mod; // [R7] [R9]
wire [CNT_W-1:0] nxt_counter = ovf ? {CNT_W{1'b0}} : counter_ff + 1'b1;

////////////////////////////////////////////////////////////////////////////////
// compare match per channel; in linked mode the active set drives channel 0
wire [CNT_W-1:0] act_cmp = link ? cmp_ff[active_sel_ff] : cmp_ff[0]; // [R1] [R3]
wire [1:0] match;
// the next count is compared so that the width equals the compare value
assign match[0] = tick & (nxt_counter == act_cmp) & (sc_ff[0][`SC_MSB] | sc_ff[0][`SC_MSA]); // [R8] [R15]
assign match[1] = tick & ~link & (nxt_counter == cmp_ff[1]) & sc_ff[1][`SC_MSA]; // [R4]

////////////////////////////////////////////////////////////////////////////////
// output state per channel
genvar g;
generate
  for (g = 0; g < 2; g = g + 1)
  begin : chan
    always @(posedge clock or negedge arst_n)
    begin
      if (!arst_n)
        pin_ff[g] <= 1'b0;
      else if (sc_ff[g][`SC_MAX] & ~sc_ff[g][`SC_TOV])
        pin_ff[g] <= 1'b1; // [R18]
      else if (match[g] && sc_ff[g][`SC_ELB])
        pin_ff[g] <= sc_ff[g][`SC_ELA]; // [R16] [R8] [R10]
      else if (match[g] && sc_ff[g][`SC_ELA])
        pin_ff[g] <= ~pin_ff[g];
      else if (ovf && sc_ff[g][`SC_TOV])
        pin_ff[g] <= ~pin_ff[g]; // [R7] [R17]
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// bus, counter and control state
always @(posedge clock or negedge arst_n)
begin
  if (!arst_n)
  begin
    overflow_flag_ff <= 1'b0;
    overflow_irq_enable_ff <= 1'b0;
    counter_halt_ff <= 1'b1;
    prescale_select_ff <= 3'h0;
    counter_ff <= {CNT_W{1'b0}};
    counter_modulo_value_ff <= `MOD_RST;
    modh_buf_ff <= 8'h00;
    mod_pend_ff <= 1'b0;
    cnth_latch_ff <= 8'h00;
    cnt_latched_ff <= 1'b0;
    sc_ff[0] <= `SC_RST;
    sc_ff[1] <= `SC_RST;
    cmp_ff[0] <= {CNT_W{1'b0}};
    cmp_ff[1] <= {CNT_W{1'b0}};
    chh_buf_ff[0] <= 8'h00;
    chh_buf_ff[1] <= 8'h00;
    active_sel_ff <= 1'b0;
    pending_sel_ff <= 1'b0;
    presc_ff <= 7'h00;
    ext_d_ff <= 1'b0;
    ack_ff <= 1'b0;
    ovf_read_ff <= 1'b0;
    chf_read_ff <= 2'h0;
    avs_readdata <= 32'h0000_0000;
    avs_waitrequest <= 1'b1;
  end
  else
  begin
    // one wait state, then acknowledge for a single cycle
    ack_ff <= (avs_read | avs_write) & bus_ok & ~ack_ff;
    avs_waitrequest <= ~((avs_read | avs_write) & bus_ok & ~ack_ff);
    if (!stop_mode) // [R22]
    begin
      ext_d_ff <= external_timer_clock_pin;
      if (run)
        presc_ff <= presc_ff + 7'h01;
      if (tick)
        counter_ff <= nxt_counter;
    end
    if (crst) // [R24]
    begin
      counter_ff <= {CNT_W{1'b0}};
      presc_ff <= 7'h00;
    end
    // linked handover at overflow
    if (ovf && link)
      active_sel_ff <= pending_sel_ff; // [R2] [R3]
    if (!link)
    begin
      active_sel_ff <= 1'b0; // [R1]
      pending_sel_ff <= 1'b0;
    end
    // overflow flag: set wins over the two-step clear
    if (ovf && !mod_pend_ff)
      overflow_flag_ff <= 1'b1; // [R19]
    else if (wr_tsc && ovf_read_ff && !wd[`TSC_OVF])
      overflow_flag_ff <= 1'b0;
    if (match[0])
      sc_ff[0][`SC_FLAG] <= 1'b1; // [R20]
    else if (wr_sc0 && chf_read_ff[0] && !wd[`SC_FLAG])
      sc_ff[0][`SC_FLAG] <= 1'b0;
    if (match[1])
      sc_ff[1][`SC_FLAG] <= 1'b1; // [R20]
    else if (wr_sc1 && chf_read_ff[1] && !wd[`SC_FLAG])
      sc_ff[1][`SC_FLAG] <= 1'b0;
    // an event or a completed write ends a pending two-step clear
    if (ovf || wr_tsc)
      ovf_read_ff <= 1'b0;
    if (match[0] || wr_sc0)
      chf_read_ff[0] <= 1'b0;
    if (match[1] || wr_sc1)
      chf_read_ff[1] <= 1'b0;
    // register writes
    if (wr)
    begin
      if (idx == `TSC_IDX)
      begin
        overflow_irq_enable_ff <= wd[`TSC_OIE];
        counter_halt_ff <= wd[`TSC_HALT];
        prescale_select_ff <= wd[`TSC_PS_HI:0];
      end
      else if (idx == `MODH_IDX)
      begin
        modh_buf_ff <= wd;
        mod_pend_ff <= 1'b1;
      end
      else if (idx == `MODL_IDX)
      begin
        counter_modulo_value_ff <= {modh_buf_ff, wd};
        mod_pend_ff <= 1'b0;
      end
      else if (idx == `SC0_IDX)
        sc_ff[0][6:0] <= wd[6:0];
      else if (idx == `CH0H_IDX)
        chh_buf_ff[0] <= wd;
      else if (idx == `CH0L_IDX)
      begin
        cmp_ff[0] <= {chh_buf_ff[0], wd};
        pending_sel_ff <= 1'b0; // [R3]
      end
      else if (idx == `SC1_IDX)
        sc_ff[1][6:0] <= {wd[6], 1'b0, wd[4:0]};
      else if (idx == `CH1H_IDX)
        chh_buf_ff[1] <= wd;
      else if (idx == `CH1L_IDX)
      begin
        cmp_ff[1] <= {chh_buf_ff[1], wd};
        pending_sel_ff <= link; // [R2]
      end
    end
    // reads: status arming for two-step clears and counter latch
    if (rd)
    begin
      avs_readdata <= 32'h0000_0000;
      if (idx == `TSC_IDX)
      begin
        avs_readdata[7:0] <= {overflow_flag_ff, overflow_irq_enable_ff, counter_halt_ff, 1'b0, 1'b0,
                              prescale_select_ff}; // [R24]
        ovf_read_ff <= overflow_flag_ff & ~ovf;
      end
      else if (idx == `CNTH_IDX)
      begin
        avs_readdata[7:0] <= counter_ff[15:8];
        cnth_latch_ff <= counter_ff[7:0];
        cnt_latched_ff <= 1'b1;
      end
      else if (idx == `CNTL_IDX)
      begin
        avs_readdata[7:0] <= cnt_latched_ff ? cnth_latch_ff : counter_ff[7:0];
        cnt_latched_ff <= 1'b0;
      end
      else if (idx == `MODH_IDX)
        avs_readdata[7:0] <= counter_modulo_value_ff[15:8];
      else if (idx == `MODL_IDX)
        avs_readdata[7:0] <= counter_modulo_value_ff[7:0];
      else if (idx == `SC0_IDX)
      begin
        avs_readdata[7:0] <= sc_ff[0]; // [R4]
        chf_read_ff[0] <= sc_ff[0][`SC_FLAG] & ~match[0];
      end
      else if (idx == `CH0H_IDX)
        avs_readdata[7:0] <= cmp_ff[0][15:8];
      else if (idx == `CH0L_IDX)
        avs_readdata[7:0] <= cmp_ff[0][7:0];
      else if (idx == `SC1_IDX)
      begin
        avs_readdata[7:0] <= sc_ff[1];
        chf_read_ff[1] <= sc_ff[1][`SC_FLAG] & ~match[1];
      end
      else if (idx == `CH1H_IDX)
        avs_readdata[7:0] <= cmp_ff[1][15:8];
      else if (idx == `CH1L_IDX)
        avs_readdata[7:0] <= cmp_ff[1][7:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// registered pins and interrupt requests
always @(posedge clock or negedge arst_n)
begin
  if (!arst_n)
  begin
    channel0_pin <= 1'b0;
    channel0_pin_oe <= 1'b0;
    channel1_pin <= 1'b0;
    channel1_pin_oe <= 1'b0;
    overflow_irq_ff <= 1'b0;
    ch0_irq_ff <= 1'b0;
    ch1_irq_ff <= 1'b0;
  end
  else
  begin
    channel0_pin <= pin_ff[0];
    channel0_pin_oe <= sc_ff[0][`SC_MSB] | sc_ff[0][`SC_MSA];
    channel1_pin <= pin_ff[1];
    channel1_pin_oe <= ~link & sc_ff[1][`SC_MSA]; // [R5] [R4]
    overflow_irq_ff <= overflow_flag_ff & overflow_irq_enable_ff; // [R19] [R21]
    ch0_irq_ff <= sc_ff[0][`SC_FLAG] & sc_ff[0][`SC_IE]; // [R20]
    ch1_irq_ff <= sc_ff[1][`SC_FLAG] & sc_ff[1][`SC_IE] & ~link;
  end
end

endmodule // pwm_timer

// ---- pwm_timer_properties.sv ----
// port-level assertion checker for the pwm timer
`timescale 1ns/1ps
module pwm_timer_checker
(
  // clock and reset
  input wire clock,
  input wire arst_n,
  // power modes
  input wire wait_mode,
  input wire stop_mode,
  // bus and outputs
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire channel0_pin,
  input wire overflow_irq_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // bus answers and lock-out
  AST_WAIT_LOCK: assert property ((wait_mode || stop_mode) && $past(wait_mode || stop_mode) |-> avs_waitrequest)
    else $error("bus answered in low power mode");
  AST_ANSWER: assert property ($rose(avs_read || avs_write) && !wait_mode && !stop_mode
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait state");
  AST_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  AST_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write) && !$past(wait_mode || stop_mode))
    else $error("answer without accepted request");
  AST_UPPER: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_HOLD: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data changed without answer");
  // stop mode freezes the output side
  AST_FREEZE: assert property (stop_mode && $past(stop_mode) && $past(stop_mode, 2) && $past(stop_mode, 3)
    |-> $stable(channel0_pin) && $stable(overflow_irq_ff))
    else $error("output moved in stop mode");
  AST_IRQ_CALM: assert property ($rose(overflow_irq_ff) |-> !$past(stop_mode, 2))
    else $error("overflow request raised while stopped");
endmodule // pwm_timer_checker

bind pwm_timer pwm_timer_checker u_pwm_timer_checker (.clock(clock), .arst_n(arst_n), .wait_mode(wait_mode),
  .stop_mode(stop_mode), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .channel0_pin(channel0_pin), .overflow_irq_ff(overflow_irq_ff));

// ---- pwm_timer_regs.vh ----
// register offsets, field positions, reset values and external prescale code of the pwm timer
`ifndef PWM_TIMER_REGS_VH
`define PWM_TIMER_REGS_VH
// word indices on the register bus
`define TSC_IDX 4'h0
`define CNTH_IDX 4'h1
`define CNTL_IDX 4'h2
`define MODH_IDX 4'h3
`define MODL_IDX 4'h4
`define SC0_IDX 4'h5
`define CH0H_IDX 4'h6
`define CH0L_IDX 4'h7
`define SC1_IDX 4'h8
`define CH1H_IDX 4'h9
`define CH1L_IDX 4'hA
// timer status control fields
`define TSC_OVF 7
`define TSC_OIE 6
`define TSC_HALT 5
`define TSC_CRST 4
`define TSC_PS_HI 2
// channel status control fields
`define SC_FLAG 7
`define SC_IE 6
`define SC_MSB 5
`define SC_MSA 4
`define SC_ELB 3
`define SC_ELA 2
`define SC_TOV 1
`define SC_MAX 0
// reset values
`define TSC_RST 8'h20
`define MOD_RST 16'hFFFF
`define SC_RST 8'h00
// prescale code selecting the external clock pin
`define PS_EXT 3'h7
`endif

// ---- tb_pwm_timer.sv ----
// self-checking bench for the pwm timer
`timescale 1ns/1ps
module tb_pwm_timer;
  reg clock = 1'b0;
  reg arst_n = 1'b0;
  reg wait_mode = 1'b0;
  reg stop_mode = 1'b0;
  reg [5:0] avs_address = 6'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, channel0_pin, channel0_pin_oe, channel1_pin, channel1_pin_oe;
  wire overflow_irq_ff, ch0_irq_ff, ch1_irq_ff, line0, line1;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer cycles = 0;
  integer hc;
  reg [31:0] got;
  reg ext_clk = 1'b0;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // external timer clock at half the bus rate
  always @(posedge clock) ext_clk <= ~ext_clk;
  pwm_timer u_pwm_timer (.clock(clock), .arst_n(arst_n), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .external_timer_clock_pin(ext_clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .channel0_pin(channel0_pin), .channel0_pin_oe(channel0_pin_oe), .channel1_pin(channel1_pin),
    .channel1_pin_oe(channel1_pin_oe), .overflow_irq_ff(overflow_irq_ff), .ch0_irq_ff(ch0_irq_ff),
    .ch1_irq_ff(ch1_irq_ff));
  pin_load u_pin_load (.channel0_pin(channel0_pin), .channel0_pin_oe(channel0_pin_oe),
    .channel1_pin(channel1_pin), .channel1_pin_oe(channel1_pin_oe), .line0(line0), .line1(line1));
  ////////////////////////////////////////
  // compare, bus access, pin measure
  task chk(input [31:0] seen, input [31:0] want);
    begin
      checks_done = checks_done + 1;
      if (seen !== want)
      begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  // one access; a read compares against d
  task bus(input rd, input [3:0] idx, input [7:0] d);
    begin
      avs_address <= {idx, 2'b00};
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= {24'h0, d};
      @(negedge clock);
      while (avs_waitrequest !== 1'b0) @(negedge clock);
      @(posedge clock);
      got = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
      if (rd)
        chk(got, {24'h0, d});
    end
  endtask
  // settle n cycles, then count high cycles of the pin line
  task measure(input integer n);
    begin
      repeat (n) @(posedge clock);
      hc = 0;
      repeat (n)
      begin
        @(negedge clock);
        hc = hc + line0;
      end
      @(posedge clock);
    end
  endtask
  // halt and clear, program modulo 255 and width, mode, then run
  task setup(input [7:0] run, input [7:0] sc, input [7:0] chv);
    begin
      bus(0, 4'h0, 8'h30);
      bus(0, 4'h3, 8'h00);
      bus(0, 4'h4, 8'hFF);
      bus(0, 4'h6, 8'h00);
      bus(0, 4'h7, chv);
      bus(0, 4'h5, sc);
      bus(0, 4'h0, run);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus(1, 4'h0, 8'h20);
    bus(1, 4'h3, 8'hFF);
    bus(1, 4'h5, 8'h00);
    bus(1, 4'hF, 8'h00);
    $display("test reset done");
    setup(8'h00, 8'h1A, 8'h80);
    measure(512);
    chk(hc, 256);
    chk({30'h0, overflow_irq_ff, ch0_irq_ff}, 32'h0);
    setup(8'h00, 8'h1A, 8'h40);
    measure(512);
    chk(hc, 128);
    setup(8'h00, 8'h1E, 8'h40);
    measure(512);
    chk(hc, 384);
    setup(8'h00, 8'h18, 8'h40);
    measure(512);
    chk(hc, 0);
    setup(8'h00, 8'h19, 8'h40);
    measure(512);
    chk(hc, 512);
    setup(8'h01, 8'h1A, 8'h40);
    measure(1024);
    chk(hc, 256);
    setup(8'h07, 8'h1A, 8'h40);
    measure(1024);
    chk(hc, 256);
    chk({31'h0, channel0_pin_oe}, 32'h1);
    $display("test unbuffered done");
    setup(8'h00, 8'h1A, 8'h40);
    wait_mode <= 1'b1;
    measure(512);
    chk(hc, 128);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    repeat (8) @(posedge clock);
    got = {31'h0, line0};
    measure(256);
    chk(hc, got[0] ? 256 : 0);
    stop_mode <= 1'b0;
    measure(512);
    chk(hc, 128);
    $display("test power modes done");
    setup(8'h00, 8'h3A, 8'h40);
    bus(0, 4'h8, 8'h19);
    measure(512);
    chk(hc, 128);
    chk({31'h0, channel1_pin_oe}, 32'h0);
    bus(0, 4'h9, 8'h00);
    bus(0, 4'hA, 8'hC0);
    measure(512);
    chk(hc, 384);
    bus(0, 4'h6, 8'h00);
    bus(0, 4'h7, 8'h20);
    measure(512);
    chk(hc, 64);
    chk({31'h0, ch1_irq_ff}, 32'h0);
    bus(0, 4'h5, 8'h1A);
    repeat (4) @(posedge clock);
    chk({29'h0, line1, channel1_pin_oe, ch1_irq_ff}, 32'h6);
    bus(0, 4'h8, 8'h59);
    repeat (300) @(posedge clock);
    chk({31'h0, ch1_irq_ff}, 32'h1);
    $display("test linked done");
    setup(8'h40, 8'h5A, 8'h40);
    repeat (600) @(posedge clock);
    chk({30'h0, overflow_irq_ff, ch0_irq_ff}, 32'h3);
    bus(0, 4'h0, 8'hE0);
    bus(1, 4'h0, 8'hE0);
    bus(0, 4'h0, 8'h60);
    bus(1, 4'h0, 8'h60);
    bus(1, 4'h5, 8'hDA);
    bus(0, 4'h5, 8'h5A);
    bus(1, 4'h5, 8'h5A);
    chk({30'h0, overflow_irq_ff, ch0_irq_ff}, 32'h0);
    $display("test flags done");
    bus(0, 4'h0, 8'h30);
    bus(1, 4'h1, 8'h00);
    bus(1, 4'h2, 8'h00);
    bus(1, 4'h0, 8'h20);
    $display("test counter reset done");
    tally_and_finish;
  end
endmodule // tb_pwm_timer
